/* File: rtl/coproc_cfg_pkg.sv */
// package: register indices, tie-off field layout, decode status and bus request types
// assumes bit 0 of each tie-off vector maps to bit 0 of its register
package coproc_cfg_pkg;
    // ****************************************
    // register file shape
    // ****************************************
    localparam int NUM_USER_INSTR = 8;
    localparam int USER_INSTR_W = 24;
    localparam int CTRL_W = 16;
    localparam int IDX_W = 3;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    // register numbers: user-instruction registers one to eight at 0..7, control at 8
    localparam logic [ADDR_W-1:0] ADDR_USER_INSTR_1 = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h8;
    // ****************************************
    // user-instruction register fields (bit positions)
    // ****************************************
    localparam int UI_PRI_OPCODE_SEL = 0;
    localparam int UI_EXT_OPCODE_LO = 1;
    localparam int UI_EXT_OPCODE_HI = 11;
    localparam int UI_PRIVILEGED = 12;
    localparam int UI_OPERAND_A_EN = 13;
    localparam int UI_OPERAND_B_EN = 14;
    localparam int UI_REG_WRITE_EN = 15;
    localparam int UI_OVERFLOW_UPD_EN = 16;
    localparam int UI_CARRY_UPD_EN = 17;
    localparam int UI_COND_FIELD_LO = 18;
    localparam int UI_COND_FIELD_HI = 20;
    localparam int UI_TYPE_LO = 21;
    localparam int UI_TYPE_HI = 22;
    localparam int UI_ENTRY_EN = 23;
    // ****************************************
    // control register fields (bit positions)
    // ****************************************
    localparam int CT_LOADSTORE_DECODE_DIS = 0;
    localparam int CT_USER_INSTR_DECODE_DIS = 1;
    localparam int CT_FORCE_USER_NONBLOCKING = 2;
    localparam int CT_FLOAT_DECODE_DIS = 3;
    localparam int CT_FLOAT_CMP_ARITH_DIS = 4;
    localparam int CT_FLOAT_CONVERT_DIS = 5;
    localparam int CT_FLOAT_ESTIMATE_DIS = 6;
    localparam int CT_FORCE_FLOAT_NONBLOCKING = 7;
    localparam int CT_STORE_WRITEBACK_PERMIT = 8;
    localparam int CT_LOADSTORE_PRIVILEGED = 9;
    localparam int CT_FORCE_ALIGNMENT = 10;
    localparam int CT_LITTLE_ENDIAN_TRAP = 11;
    localparam int CT_BIG_ENDIAN_TRAP = 12;
    localparam int CT_BIG_ENDIAN_STEERING = 13;
    localparam int CT_CLOCK_DIVIDE_SETTING = 14;
    localparam int CT_COPROCESSOR_ENABLE = 15;
    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic carry_flag_out;
        logic controller_decoded_flag;
        logic [IDX_W-1:0] matched_user_instr_index;
        logic matched_user_instr_valid;
    } decode_status_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;
endpackage : coproc_cfg_pkg

/* File: rtl/coproc_cfg_reset_and_decode.sv */
// configuration registers with tie-off reset values, plus decode status to the coprocessor
// assumes instruction fields and carry come from same-clock processor logic
//
// Summary of operation
// - carry output follows the processor carry flag
// - decoded flag high when controller itself decoded the presented instruction
// - three-bit index of matched user instruction with separate valid qualifier
// - reset clears all configuration registers; they load from their tie-off vectors on the first enabled clock after release
// - after reset software may overwrite any configuration register over the bus
// - eight 24-bit user-instruction registers, each reset from its own vector
// - one 16-bit control register reset from a 16-bit vector
// - user bits 0..15: opcode select, extended opcode, privileged, operands, write
// - user bits 16..23: overflow, carry, condition field, type, entry enable
// - control bits 0..7: decode disables and forced non-blocking modes
// - control bits 8..15: store, privilege, alignment, endian, divide, enable
`timescale 1ns/10ps
module coproc_cfg_reset_and_decode
    import coproc_cfg_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    // tie-off vectors
    input wire logic [NUM_USER_INSTR*USER_INSTR_W-1:0] user_instr_tie_vector_i,
    input wire logic [CTRL_W-1:0] control_tie_vector_i,
    // device control register bus
    input wire reg_req_t reg_req_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    output logic reg_ack_o,
    // instruction being presented to the coprocessor
    input wire logic instr_valid_i,
    input wire logic [5:0] instr_primary_opcode_i,
    input wire logic [10:0] instr_extended_opcode_i,
    input wire logic carry_flag_i,
    // decode status toward the coprocessor
    output decode_status_t decode_status_o,
    // control register fields used elsewhere in the controller
    output logic [CTRL_W-1:0] coproc_ctrl_config_o
);
    // ****************************************
    // tie-off capture after reset release
    // ****************************************
    logic load_pending_q;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            load_pending_q <= 1'b1;
        end else if (clk_en_i) begin
            load_pending_q <= 1'b0;
        end
    end

    // ****************************************
    // register file
    // ****************************************
    logic [USER_INSTR_W-1:0] user_instr_cfg_q [NUM_USER_INSTR];
    logic [CTRL_W-1:0] coproc_ctrl_config_q;
    wire logic wr_ctrl = reg_req_i.wr && (reg_req_i.addr == ADDR_CTRL);

    for (genvar g = 0; g < NUM_USER_INSTR; g++) begin : g_ui
        localparam logic [ADDR_W-1:0] ADDR_G = ADDR_USER_INSTR_1 + ADDR_W'(g);
        wire logic wr_g = reg_req_i.wr && (reg_req_i.addr == ADDR_G);
        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                user_instr_cfg_q[g] <= '0;
            end else if (clk_en_i) begin
                if (load_pending_q) begin
                    user_instr_cfg_q[g] <= user_instr_tie_vector_i[g*USER_INSTR_W +: USER_INSTR_W];
                end else if (wr_g) begin
                    user_instr_cfg_q[g] <= reg_req_i.wdata[USER_INSTR_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            coproc_ctrl_config_q <= '0;
        end else if (clk_en_i) begin
            if (load_pending_q) begin
                coproc_ctrl_config_q <= control_tie_vector_i;
            end else if (wr_ctrl) begin
                coproc_ctrl_config_q <= reg_req_i.wdata[CTRL_W-1:0];
            end
        end
    end

    // ****************************************
    // register read
    // ****************************************
    wire logic addr_is_ui = reg_req_i.addr < (ADDR_USER_INSTR_1 + ADDR_W'(NUM_USER_INSTR));
    wire logic [2:0] ui_sel = reg_req_i.addr[2:0];
    wire logic [DATA_W-1:0] rd_mux = addr_is_ui ?
        {{(DATA_W-USER_INSTR_W){1'b0}}, user_instr_cfg_q[ui_sel]} :
        (reg_req_i.addr == ADDR_CTRL) ? {{(DATA_W-CTRL_W){1'b0}}, coproc_ctrl_config_q} : '0;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= '0;
            reg_ack_o <= 1'b0;
        end else if (clk_en_i) begin
            reg_ack_o <= reg_req_i.wr || reg_req_i.rd;
            reg_rdata_o <= reg_req_i.rd ? rd_mux : '0;
        end
    end

    // ****************************************
    // user-instruction match
    // ****************************************
    localparam logic [5:0] USER_PRIMARY_OPCODE_A = 6'h04;
    localparam logic [5:0] USER_PRIMARY_OPCODE_B = 6'h00;
    wire logic [NUM_USER_INSTR-1:0] hit;
    for (genvar g = 0; g < NUM_USER_INSTR; g++) begin : g_match
        wire logic [USER_INSTR_W-1:0] c = user_instr_cfg_q[g];
        wire logic [5:0] prim = c[UI_PRI_OPCODE_SEL] ? USER_PRIMARY_OPCODE_A
                                                    : USER_PRIMARY_OPCODE_B;
        assign hit[g] = c[UI_ENTRY_EN]
            && (instr_primary_opcode_i == prim)
            && (instr_extended_opcode_i == c[UI_EXT_OPCODE_HI:UI_EXT_OPCODE_LO]);
    end

    logic [IDX_W-1:0] hit_idx;
    always_comb begin
        hit_idx = '0;
        for (int i = NUM_USER_INSTR - 1; i >= 0; i--) begin
            if (hit[i]) begin
                hit_idx = IDX_W'(i);
            end
        end
    end

    wire logic ui_decode_on = coproc_ctrl_config_q[CT_COPROCESSOR_ENABLE]
        && !coproc_ctrl_config_q[CT_USER_INSTR_DECODE_DIS];
    wire logic any_hit = instr_valid_i && ui_decode_on && (|hit);

    // ****************************************
    // decode status outputs
    // ****************************************
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            decode_status_o <= '0;
        end else if (clk_en_i) begin
            decode_status_o.carry_flag_out <= carry_flag_i;
            decode_status_o.controller_decoded_flag <= any_hit;
            decode_status_o.matched_user_instr_index <= any_hit ? hit_idx : '0;
            decode_status_o.matched_user_instr_valid <= any_hit;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            coproc_ctrl_config_o <= '0;
        end else if (clk_en_i) begin
            coproc_ctrl_config_o <= coproc_ctrl_config_q;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    property p_carry;
        @(posedge clk_i) disable iff (sys_rst_i)
        clk_en_i |=> decode_status_o.carry_flag_out == $past(carry_flag_i);
    endproperty
    a_carry: assert property (p_carry) else $error("carry out mismatch");

    property p_decoded;
        @(posedge clk_i) disable iff (sys_rst_i)
        (clk_en_i && !any_hit) |=> !decode_status_o.controller_decoded_flag;
    endproperty
    a_decoded: assert property (p_decoded) else $error("decoded flag without match");

    property p_index;
        @(posedge clk_i) disable iff (sys_rst_i)
        (clk_en_i && any_hit) |=> decode_status_o.matched_user_instr_valid
            && ((($past(hit) >> decode_status_o.matched_user_instr_index)
                & NUM_USER_INSTR'(1)) != '0)
            && (($past(hit) & ((NUM_USER_INSTR'(1) << decode_status_o.matched_user_instr_index)
                - NUM_USER_INSTR'(1))) == '0);
    endproperty
    a_index: assert property (p_index) else $error("index not lowest match");

    property p_tie_load;
        @(posedge clk_i) disable iff (sys_rst_i)
        (clk_en_i && load_pending_q) |=> coproc_ctrl_config_q == $past(control_tie_vector_i);
    endproperty
    a_tie_load: assert property (p_tie_load) else $error("control not loaded from tie");

    property p_write;
        @(posedge clk_i) disable iff (sys_rst_i)
        (clk_en_i && !load_pending_q && wr_ctrl)
            |=> coproc_ctrl_config_q == $past(reg_req_i.wdata[CTRL_W-1:0]);
    endproperty
    a_write: assert property (p_write) else $error("control write lost");

    property p_ui_load;
        @(posedge clk_i) disable iff (sys_rst_i)
        (clk_en_i && load_pending_q)
            |=> user_instr_cfg_q[NUM_USER_INSTR-1]
            == $past(user_instr_tie_vector_i[(NUM_USER_INSTR-1)*USER_INSTR_W +: USER_INSTR_W]);
    endproperty
    a_ui_load: assert property (p_ui_load) else $error("user reg 8 not loaded");

    property p_ctrl_out;
        @(posedge clk_i) disable iff (sys_rst_i)
        clk_en_i |=> coproc_ctrl_config_o == $past(coproc_ctrl_config_q);
    endproperty
    a_ctrl_out: assert property (p_ctrl_out) else $error("control output stale");

    property p_disable;
        @(posedge clk_i) disable iff (sys_rst_i)
        (clk_en_i && coproc_ctrl_config_q[CT_USER_INSTR_DECODE_DIS])
            |=> !decode_status_o.matched_user_instr_valid;
    endproperty
    a_disable: assert property (p_disable) else $error("decode while disabled");

    property p_persist;
        @(posedge clk_i) disable iff (sys_rst_i)
        (!load_pending_q && !wr_ctrl) |=> $stable(coproc_ctrl_config_q);
    endproperty
    a_persist: assert property (p_persist) else $error("control changed unwritten");

    c_hit: cover property (@(posedge clk_i) disable iff (sys_rst_i) any_hit && clk_en_i);
    c_write: cover property (@(posedge clk_i) disable iff (sys_rst_i) wr_ctrl && clk_en_i);
    c_read: cover property (@(posedge clk_i) disable iff (sys_rst_i) reg_req_i.rd && clk_en_i);
endmodule : coproc_cfg_reset_and_decode

/* File: bench/coproc_fabric_model.sv */
// fabric-side model: takes decode status and counts the user instructions it is handed
// assumes the controller clock and reset; one status sample per clock, as the model has no clock enable
`timescale 1ns/10ps
module coproc_fabric_model
    import coproc_cfg_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // decode status from the controller
    input wire decode_status_t decode_status_i,
    // number of qualified user-instruction indices seen
    output logic [7:0] hit_count_o
);
    // an index counts only while its valid qualifier is high
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hit_count_o <= 8'h00;
        end else if (decode_status_i.matched_user_instr_valid) begin
            hit_count_o <= hit_count_o + 8'h01;
        end
    end
endmodule : coproc_fabric_model

/* File: bench/coproc_cfg_reset_and_decode_test.sv */
// testbench: tie-off reset values, register writes and decode status
// assumes register n at address n-1, control at 8, one-cycle ack and status latency
`timescale 1ns/10ps
module coproc_cfg_reset_and_decode_test;
    import coproc_cfg_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic clk_en_i = 1'b1;
    logic [NUM_USER_INSTR*USER_INSTR_W-1:0] user_tie = '0;
    logic [CTRL_W-1:0] ctrl_tie = 16'h8a55;
    reg_req_t req = '0;
    logic [DATA_W-1:0] rdata;
    logic ack;
    logic instr_valid = 1'b0;
    logic [5:0] prim = 6'h00;
    logic [10:0] ext = 11'h000;
    logic carry = 1'b0;
    decode_status_t status;
    logic [CTRL_W-1:0] ctrl_o;
    logic [7:0] hits;
    int failures = 0;
    int n_checks = 0;

    coproc_cfg_reset_and_decode dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
        .user_instr_tie_vector_i(user_tie), .control_tie_vector_i(ctrl_tie),
        .reg_req_i(req), .reg_rdata_o(rdata), .reg_ack_o(ack), .instr_valid_i(instr_valid),
        .instr_primary_opcode_i(prim), .instr_extended_opcode_i(ext), .carry_flag_i(carry),
        .decode_status_o(status), .coproc_ctrl_config_o(ctrl_o));
    coproc_fabric_model fabric (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .decode_status_i(status),
        .hit_count_o(hits));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [23:0] tie_of(input int n);
        tie_of = 24'h8a5000 | (24'(n + 16) << 1) | 24'(n % 2);
    endfunction : tie_of

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [31:0] exp);
        @(posedge clk_i);
        #1 req = '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(posedge clk_i);
        #1 req = '0;
        check({31'h0, ack}, 32'h1);
        if (!wr) check(rdata, exp);
    endtask : bus

    task automatic decode(input logic [23:0] v, input logic c, input logic hit,
                          input logic [2:0] idx);
        @(posedge clk_i);
        #1 instr_valid = 1'b1;
        prim = v[0] ? 6'h04 : 6'h00;
        ext = v[11:1];
        carry = c;
        @(posedge clk_i);
        #1 instr_valid = 1'b0;
        check({29'h0, status.carry_flag_out, status.controller_decoded_flag,
               status.matched_user_instr_valid}, {29'h0, c, hit, hit});
        if (hit) check({29'h0, status.matched_user_instr_index}, {29'h0, idx});
    endtask : decode

    task automatic print_verdict();
        if (failures == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict

    // ****************************************
    // scenarios
    // ****************************************
    task automatic reset_values();
        for (int n = 0; n < NUM_USER_INSTR; n++) begin
            bus(1'b0, 4'(n), 32'h0, {8'h00, tie_of(n + 1)});
        end
        bus(1'b0, ADDR_CTRL, 32'h0, {16'h0000, ctrl_tie});
        check({16'h0000, ctrl_o}, {16'h0000, ctrl_tie});
    endtask : reset_values

    task automatic decode_cases();
        for (int n = 1; n <= NUM_USER_INSTR; n++) begin
            decode(tie_of(n), n[0], 1'b1, 3'(n - 1));
        end
        decode(24'h000ffe, 1'b1, 1'b0, 3'h0);
        bus(1'b1, 4'h4, {8'h00, tie_of(3)}, 32'h0);
        decode(tie_of(3), 1'b0, 1'b1, 3'h2);
        decode(tie_of(5), 1'b1, 1'b0, 3'h0);
        bus(1'b1, 4'h2, {8'h00, tie_of(3) & 24'h7fffff}, 32'h0);
        decode(tie_of(3), 1'b1, 1'b1, 3'h4);
        bus(1'b1, ADDR_CTRL, {16'h0000, ctrl_tie | 16'h0002}, 32'h0);
        decode(tie_of(1), 1'b0, 1'b0, 3'h0);
        bus(1'b1, ADDR_CTRL, {16'h0000, ctrl_tie & 16'h7fff}, 32'h0);
        decode(tie_of(1), 1'b1, 1'b0, 3'h0);
        check({16'h0000, ctrl_o}, {16'h0000, ctrl_tie & 16'h7fff});
        check({24'h0, hits}, 32'd10);
    endtask : decode_cases

    task automatic write_read();
        logic [31:0] d;
        for (int a = 0; a <= 8; a++) begin
            d = 32'hc3a5_9600 + 32'(a);
            bus(1'b1, 4'(a), d, 32'h0);
            bus(1'b0, 4'(a), 32'h0, d & (a == 8 ? 32'h0000ffff : 32'h00ffffff));
        end
        bus(1'b1, 4'hd, 32'hffff_ffff, 32'h0);
        bus(1'b0, 4'hd, 32'h0, 32'h0);
    endtask : write_read

    task automatic freeze();
        @(posedge clk_i);
        #1 clk_en_i = 1'b0;
        carry = 1'b0;
        req = '{wr: 1'b1, rd: 1'b0, addr: ADDR_CTRL, wdata: 32'h0000_ffff};
        repeat (3) @(posedge clk_i);
        #1 check({30'h0, ack, status.carry_flag_out}, {30'h0, 1'b0, 1'b1});
        check({16'h0000, ctrl_o}, {16'h0000, ctrl_tie & 16'h7fff});
        req = '0;
        clk_en_i = 1'b1;
        bus(1'b0, ADDR_CTRL, 32'h0, {16'h0000, ctrl_tie & 16'h7fff});
        check({31'h0, status.carry_flag_out}, 32'h0);
    endtask : freeze

    task automatic rereset();
        @(posedge clk_i);
        #1 sys_rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        repeat (2) @(posedge clk_i);
        reset_values();
    endtask : rereset

    initial begin
        #200000;
        failures++;
        print_verdict();
    end

    initial begin
        for (int n = 0; n < NUM_USER_INSTR; n++) begin
            user_tie[n*USER_INSTR_W +: USER_INSTR_W] = tie_of(n + 1);
        end
        repeat (8) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        repeat (2) @(posedge clk_i);
        reset_values();
        decode_cases();
        freeze();
        write_read();
        rereset();
        print_verdict();
    end
endmodule : coproc_cfg_reset_and_decode_test
